// ===== hw/rwpe_consts.svh
`ifndef RWPE_CONSTS_SVH
`define RWPE_CONSTS_SVH

// ----------------------------------------------------------------
// System clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25

// ----------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------
// Longest reinitialisation time, rounded down to whole cycles
`define T_REINIT_MAX_NS 1000000
`define REINIT_CYCLES (`T_REINIT_MAX_NS / `CLK_PERIOD_NS)
// Watchdog overflow interval, rounded down
`define T_WDT_NS 1000000000
`define WDT_CYCLES (`T_WDT_NS / `CLK_PERIOD_NS)
// Least pin hold time that requests serial programming, rounded up
`define T_ISP_HOLD_NS 4200000
`define ISP_HOLD_CYCLES ((`T_ISP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Least reset pulse from the host, rounded up
`define T_PIN_MIN_NS 20
`define PIN_MIN_CYCLES ((`T_PIN_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Synchroniser lane positions and reset values
// ----------------------------------------------------------------
`define SYNC_WIDTH 4
`define SYNC_POWER_GOOD 0
`define SYNC_SUPPLY_LOW 1
`define SYNC_PIN_N 2
`define SYNC_XTAL 3
`define SYNC_RESET_VAL 4'h4

`endif

// ===== hw/rwpe_pkg.sv
package rwpe_pkg;

	// Reset cause; declaration order is also the priority order
	typedef enum logic [2:0] {
		CAUSE_POR,
		CAUSE_BOR,
		CAUSE_PIN,
		CAUSE_WDT,
		CAUSE_SOFT
	} reset_cause_t;

	// Reset sequencer states
	typedef enum logic [1:0] {
		SEQ_HOLD,
		SEQ_REINIT,
		SEQ_RUN
	} seq_state_t;

	// Programming unit modes
	typedef enum logic [1:0] {
		PROG_NORMAL,
		PROG_WAIT_UNLOCK,
		PROG_ISP,
		PROG_APM
	} prog_mode_t;

endpackage

// ===== hw/pin_sync.sv
// ----------------------------------------------------------------
// Three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------
module pin_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Asynchronous levels in, filtered levels out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] level_o
);

	generate
		if (WIDTH < 1) begin : g_bad
			$error("pin_sync needs at least one lane");
		end
		for (genvar g = 0; g < WIDTH; g++) begin : g_lane
			logic s1; // Metastable stage, read only by s2
			logic s2;
			logic s3;
			// Shift chain; a change counts only once s2 and s3 agree
			always_ff @(posedge clk_sys_i or negedge rstn_i) begin
				if (!rstn_i) begin
					s1 <= RESET_VAL[g];
					s2 <= RESET_VAL[g];
					s3 <= RESET_VAL[g];
					level_o[g] <= RESET_VAL[g];
				end else begin
					s1 <= async_i[g];
					s2 <= s1;
					s3 <= s2;
					if (s2 == s3) begin
						level_o[g] <= s3;
					end
				end
			end
		end
	endgenerate

endmodule

// ===== hw/wdt_counter.sv
// ----------------------------------------------------------------
// Watchdog interval counter
// ----------------------------------------------------------------
module wdt_counter #(
	parameter int CYCLES = 40000000
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Control
	input wire logic run_i, // Count only while high; low clears
	input wire logic clear_i, // Software kick
	// Status
	output logic overflow_o // One-cycle pulse
);

	localparam int CNT_W = $clog2(CYCLES);

	generate
		if (CYCLES < 2) begin : g_bad
			$error("wdt_counter needs CYCLES of at least 2");
		end
	endgenerate

	logic [CNT_W-1:0] cnt; // Cycles since last clear

	// Counter; stopping also clears, so a restart begins from zero
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= '0;
			overflow_o <= 1'b0;
		end else if (!run_i || clear_i) begin
			cnt <= '0;
			overflow_o <= 1'b0;
		end else if (cnt == CNT_W'(CYCLES - 1)) begin
			cnt <= '0;
			overflow_o <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			overflow_o <= 1'b0;
		end
	end

endmodule

// ===== hw/reset_watchdog_prog_entry.sv
`include "rwpe_consts.svh"

module reset_watchdog_prog_entry
	import rwpe_pkg::*;
#(
	parameter int REINIT_CYCLES = `REINIT_CYCLES,
	parameter int WDT_CYCLES = `WDT_CYCLES,
	parameter int ISP_HOLD_CYCLES = `ISP_HOLD_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Supply monitors, crystal and reset pin (asynchronous)
	input wire logic power_good_i,
	input wire logic supply_low_i,
	input wire logic reset_pin_n_i,
	input wire logic xtal_stable_i,
	// Software controls (system clock domain)
	input wire logic sw_reset_i,
	input wire logic wdt_clear_i,
	input wire logic wdt_mask_i,
	input wire logic power_down_i,
	input wire logic apm_request_i,
	// Programming unit and serial port
	input wire logic unlock_cmd_i,
	input wire logic uart_tx_data_i,
	// Reset and GPIO state
	output logic cpu_reset_n_o,
	output reset_cause_t reset_cause_o,
	output logic gpio_hiz_pullup_o,
	// Programming state
	output prog_mode_t prog_mode_o,
	output logic flash_wr_uart_en_o,
	output logic flash_wr_usb_en_o,
	// Serial transmit pin
	output logic txd_o,
	output logic txd_oe_o
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	localparam int REINIT_W = $clog2(REINIT_CYCLES);
	localparam int HOLD_W = $clog2(ISP_HOLD_CYCLES + 1);

	generate
		if (REINIT_CYCLES < 2) begin : g_bad_reinit
			$error("REINIT_CYCLES must be at least 2");
		end
		if (ISP_HOLD_CYCLES <= `PIN_MIN_CYCLES) begin : g_bad_hold
			$error("ISP_HOLD_CYCLES must exceed the least pin pulse");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [`SYNC_WIDTH-1:0] sync_raw; // Unsynchronised inputs
	logic [`SYNC_WIDTH-1:0] sync_lvl; // Filtered inputs
	logic power_good; // Supply sufficient
	logic supply_low; // Below operating level
	logic pin_n; // Reset pin level
	logic xtal_ok; // Crystal oscillating stably
	logic por_req; // Power-on reset request
	logic bor_req; // Brown-out reset request
	logic pin_req; // External pin reset request
	logic wdt_ovf; // Watchdog overflow pulse
	logic wdt_req; // Unmasked watchdog request
	logic soft_req; // Software reset request
	logic level_req; // Any request that holds reset
	logic any_req; // Any request at all
	logic wdt_run; // Watchdog counting enable
	reset_cause_t top_cause; // Highest-priority cause now
	seq_state_t seq; // Sequencer state
	prog_mode_t prog; // Programming unit mode
	logic [REINIT_W-1:0] reinit_cnt; // Cycles spent reinitialising
	logic [HOLD_W-1:0] hold_cnt; // Cycles the pin has been low
	logic long_hold; // Pin held long enough
	logic apm_pending; // Auto programming requested

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	// Short host pulses near the least width may be lost in the
	// filter; a pulse of three cycles is always seen
	always_comb begin
		sync_raw = '0;
		sync_raw[`SYNC_POWER_GOOD] = power_good_i;
		sync_raw[`SYNC_SUPPLY_LOW] = supply_low_i;
		sync_raw[`SYNC_PIN_N] = reset_pin_n_i;
		sync_raw[`SYNC_XTAL] = xtal_stable_i;
	end

	pin_sync #(
		.WIDTH(`SYNC_WIDTH),
		.RESET_VAL(`SYNC_RESET_VAL)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.async_i(sync_raw),
		.level_o(sync_lvl)
	);

	assign power_good = sync_lvl[`SYNC_POWER_GOOD];
	assign supply_low = sync_lvl[`SYNC_SUPPLY_LOW];
	assign pin_n = sync_lvl[`SYNC_PIN_N];
	assign xtal_ok = sync_lvl[`SYNC_XTAL];

	// ----------------------------------------------------------------
	// Reset requests
	// ----------------------------------------------------------------
	// The level sources cannot be masked; only the watchdog can
	assign por_req = !power_good;
	assign bor_req = power_good && supply_low;
	assign pin_req = !pin_n;
	assign wdt_req = wdt_ovf && !wdt_mask_i && (seq == SEQ_RUN);
	assign soft_req = sw_reset_i && (seq == SEQ_RUN);
	assign level_req = por_req || bor_req || pin_req;
	assign any_req = level_req || wdt_req || soft_req;

	// Fixed priority among simultaneous causes
	always_comb begin
		if (por_req) begin
			top_cause = CAUSE_POR;
		end else if (bor_req) begin
			top_cause = CAUSE_BOR;
		end else if (pin_req) begin
			top_cause = CAUSE_PIN;
		end else if (wdt_req) begin
			top_cause = CAUSE_WDT;
		end else begin
			top_cause = CAUSE_SOFT;
		end
	end

	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	// Held while any level source stands, then reinitialises until
	// the crystal is stable, never beyond the longest allowed time
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			seq <= SEQ_HOLD;
		end else if (level_req) begin
			seq <= SEQ_HOLD;
		end else begin
			unique case (seq)
				SEQ_HOLD: begin
					seq <= SEQ_REINIT;
				end
				SEQ_REINIT: begin
					// Timeout caps reinit at REINIT_CYCLES cycles, the longest allowed time
					if (xtal_ok || reinit_cnt == REINIT_W'(REINIT_CYCLES - 1)) begin
						seq <= SEQ_RUN;
					end
				end
				SEQ_RUN: begin
					// Pulse sources pass through hold for one cycle
					if (any_req) begin
						seq <= SEQ_HOLD;
					end
				end
			endcase
		end
	end

	// Reinitialisation timer, cleared outside its state
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reinit_cnt <= '0;
		end else if (seq != SEQ_REINIT) begin
			reinit_cnt <= '0;
		end else begin
			reinit_cnt <= reinit_cnt + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Cause latch
	// ----------------------------------------------------------------
	// A new reset from run overwrites; during a reset only a higher
	// priority cause may replace the one already held
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reset_cause_o <= CAUSE_POR;
		end else if (any_req && (seq == SEQ_RUN || top_cause < reset_cause_o)) begin
			reset_cause_o <= top_cause;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	// Runs only while code executes and not powered down; stopping
	// clears the count so a wake starts a full interval
	assign wdt_run = (seq == SEQ_RUN) && (prog == PROG_NORMAL) && !power_down_i;

	wdt_counter #(
		.CYCLES(WDT_CYCLES)
	) u_wdt (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.run_i(wdt_run),
		.clear_i(wdt_clear_i),
		.overflow_o(wdt_ovf)
	);

	// ----------------------------------------------------------------
	// Programming entry
	// ----------------------------------------------------------------
	// Pin low time, saturating at the threshold
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hold_cnt <= '0;
		end else if (!pin_req) begin
			hold_cnt <= '0;
		end else if (!long_hold) begin
			hold_cnt <= hold_cnt + 1'b1;
		end
	end

	assign long_hold = (hold_cnt == HOLD_W'(ISP_HOLD_CYCLES));

	// Auto programming request; set only in run, taken at reset exit,
	// so the two never meet in one cycle
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			apm_pending <= 1'b0;
		end else if (apm_request_i && seq == SEQ_RUN && prog == PROG_NORMAL) begin
			apm_pending <= 1'b1;
		end else if (seq == SEQ_HOLD && !level_req) begin
			apm_pending <= 1'b0;
		end
	end

	// Programming mode; the default after reset is normal execution
	// with serial programming reachable by a long pin hold
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prog <= PROG_NORMAL;
		end else if ((seq == SEQ_RUN && any_req) || por_req || bor_req) begin
			// Every fresh reset leaves any programming mode
			prog <= PROG_NORMAL;
		end else if (pin_req && long_hold) begin
			prog <= PROG_WAIT_UNLOCK;
		end else if (seq == SEQ_HOLD && !level_req && apm_pending) begin
			prog <= PROG_APM;
		end else if (prog == PROG_WAIT_UNLOCK && !pin_req && unlock_cmd_i) begin
			// Serial port stays quiet until the host unlocks
			prog <= PROG_ISP;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// Processor runs only after reinit and outside programming
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cpu_reset_n_o <= 1'b0;
		end else begin
			cpu_reset_n_o <= (seq == SEQ_RUN) && (prog == PROG_NORMAL);
		end
	end

	// GPIO float with pull-up during resets of the hard causes;
	// software resets leave the pins alone
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gpio_hiz_pullup_o <= 1'b1;
		end else begin
			gpio_hiz_pullup_o <= (seq != SEQ_RUN) && (reset_cause_o != CAUSE_SOFT);
		end
	end

	// Programming mode and flash write paths
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prog_mode_o <= PROG_NORMAL;
			flash_wr_uart_en_o <= 1'b0;
			flash_wr_usb_en_o <= 1'b0;
		end else begin
			prog_mode_o <= prog;
			flash_wr_uart_en_o <= (prog == PROG_ISP) || (prog == PROG_APM);
			flash_wr_usb_en_o <= (prog == PROG_APM);
		end
	end

	// Transmit pin: driven in normal run or serial programming only;
	// costs one cycle of delay on the data
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			txd_o <= 1'b1;
			txd_oe_o <= 1'b0;
		end else begin
			txd_o <= uart_tx_data_i;
			txd_oe_o <= ((seq == SEQ_RUN) && (prog == PROG_NORMAL)) || (prog == PROG_ISP);
		end
	end

endmodule

// ===== verification/host_model.sv
// ----------------------------------------------------------------
// Host side: reset pin driver and unlock command source
// ----------------------------------------------------------------
module host_model (
	// Clock
	input wire logic clk_sys_i,
	// Requests from the bench
	input wire logic go_i,
	input wire logic [31:0] low_cycles_i,
	input wire logic unlock_go_i,
	// Pin and decoded command toward the device
	output logic pin_n_o,
	output logic unlock_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pin idles high, as the board pull-up would leave it; one process
	// owns the pin and holds it low a whole number of cycles, never under one
	initial begin
		pin_n_o = 1'b1;
		forever begin
			@(posedge clk_sys_i);
			if (go_i) begin
				pin_n_o <= 1'b0;
				repeat ((low_cycles_i < 1) ? 1 : low_cycles_i) @(posedge clk_sys_i);
				pin_n_o <= 1'b1;
			end
		end
	end
	// Unlock command copies the bench request one cycle later and lasts as long as that request
	initial begin
		unlock_o = 1'b0;
		forever @(posedge clk_sys_i) unlock_o <= unlock_go_i;
	end
endmodule

// ===== verification/reset_watchdog_prog_entry_checker.sv
module reset_watchdog_prog_entry_checker
	import rwpe_pkg::*;
#(
	parameter int REINIT_CYCLES = 16,
	parameter int WDT_CYCLES = 64,
	parameter int ISP_HOLD_CYCLES = 32
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Watched inputs
	input wire logic power_good_i,
	input wire logic supply_low_i,
	input wire logic reset_pin_n_i,
	input wire logic wdt_clear_i,
	input wire logic wdt_mask_i,
	input wire logic power_down_i,
	// Watched outputs
	input wire logic cpu_reset_n_o,
	input wire reset_cause_t reset_cause_o,
	input wire logic gpio_hiz_pullup_o,
	input wire prog_mode_t prog_mode_o,
	input wire logic flash_wr_uart_en_o,
	input wire logic flash_wr_usb_en_o,
	input wire logic txd_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	int held_cnt; // Cycles held with no request standing
	int run_cnt; // Cycles running with no kick, mask or power-down
	int pin_cnt; // Consecutive low samples of the pin
	// Counters restart whenever their condition breaks
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			held_cnt <= 0;
			run_cnt <= 0;
			pin_cnt <= 0;
		end else begin
			held_cnt <= (!cpu_reset_n_o && power_good_i && !supply_low_i && reset_pin_n_i
				&& prog_mode_o == PROG_NORMAL) ? held_cnt + 1 : 0;
			run_cnt <= (cpu_reset_n_o && !wdt_clear_i && !wdt_mask_i && !power_down_i) ? run_cnt + 1 : 0;
			pin_cnt <= reset_pin_n_i ? 0 : pin_cnt + 1;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_power_holds_cpu: assert property (!power_good_i [*7] |-> !cpu_reset_n_o)
		else $error("processor released while supply not good");
	a_brownout_resets: assert property ((power_good_i && supply_low_i) [*7] |-> !cpu_reset_n_o)
		else $error("low supply did not hold processor");
	a_reinit_bounded: assert property (held_cnt <= REINIT_CYCLES + 8)
		else $error("reinitialisation overran its bound");
	a_por_cause_wins: assert property (!power_good_i [*6] |-> reset_cause_o == CAUSE_POR)
		else $error("power-on cause not latched");
	a_hard_gpio_hiz: assert property ($fell(cpu_reset_n_o) && reset_cause_o != CAUSE_SOFT |-> gpio_hiz_pullup_o)
		else $error("gpio not hi-Z on hard reset");
	a_wdt_mask_blocks: assert property ($fell(cpu_reset_n_o) && $past(wdt_mask_i, 2) && $past(wdt_mask_i, 3)
		|-> reset_cause_o != CAUSE_WDT)
		else $error("masked watchdog caused reset");
	a_wdt_overflow_bound: assert property (run_cnt <= WDT_CYCLES + 3)
		else $error("watchdog did not overflow in time");
	a_pin_holds_reset: assert property (!reset_pin_n_i [*7] |-> !cpu_reset_n_o)
		else $error("low pin did not hold processor");
	a_txd_hiz_reset: assert property ($fell(cpu_reset_n_o) || (prog_mode_o == PROG_WAIT_UNLOCK
		&& $past(prog_mode_o) == PROG_WAIT_UNLOCK) |-> !txd_oe_o)
		else $error("transmit driven in reset");
	a_isp_after_unlock: assert property (prog_mode_o == PROG_ISP && $past(prog_mode_o) != PROG_ISP
		|-> $past(prog_mode_o) == PROG_WAIT_UNLOCK)
		else $error("serial programming entered without unlock wait");
	a_isp_hold_time: assert property (prog_mode_o == PROG_WAIT_UNLOCK && $past(prog_mode_o) != PROG_WAIT_UNLOCK
		|-> pin_cnt >= ISP_HOLD_CYCLES)
		else $error("programming wait entered on short pin hold");
	a_apm_flash_paths: assert property (prog_mode_o == PROG_APM && $past(prog_mode_o) == PROG_APM
		|-> flash_wr_uart_en_o && flash_wr_usb_en_o)
		else $error("auto programming lacks a flash path");
	// Main scenarios reached
	c_wdt_reset: cover property ($fell(cpu_reset_n_o) && reset_cause_o == CAUSE_WDT);
	c_isp_mode: cover property (prog_mode_o == PROG_ISP);
	c_apm_mode: cover property (prog_mode_o == PROG_APM);
endmodule

bind reset_watchdog_prog_entry reset_watchdog_prog_entry_checker #(.REINIT_CYCLES(REINIT_CYCLES),
	.WDT_CYCLES(WDT_CYCLES), .ISP_HOLD_CYCLES(ISP_HOLD_CYCLES)) checker_u (.clk_sys_i, .rstn_i, .power_good_i,
	.supply_low_i, .reset_pin_n_i, .wdt_clear_i, .wdt_mask_i, .power_down_i, .cpu_reset_n_o, .reset_cause_o,
	.gpio_hiz_pullup_o, .prog_mode_o, .flash_wr_uart_en_o, .flash_wr_usb_en_o, .txd_oe_o);

// ===== verification/reset_watchdog_prog_entry_bench.sv
module reset_watchdog_prog_entry_bench
	import rwpe_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// Short counts keep the run brief
	localparam int RC = 16;
	localparam int WC = 64;
	localparam int HC = 32;
	logic clk_sys_i = 0, rstn_i = 0, power_good_i = 0, supply_low_i = 0, xtal_stable_i = 0;
	logic sw_reset_i = 0, wdt_clear_i = 0, wdt_mask_i = 0, power_down_i = 0, apm_request_i = 0;
	logic uart_tx_data_i = 1, host_go = 0, unlock_go = 0, reset_pin_n_i, unlock_cmd_i;
	logic cpu_reset_n_o, gpio_hiz_pullup_o, flash_wr_uart_en_o, flash_wr_usb_en_o, txd_o, txd_oe_o;
	logic [31:0] low_len = 4;
	logic [1:0] hist = 2'b11; // Last two transmit bits sent
	reset_cause_t reset_cause_o;
	prog_mode_t prog_mode_o;
	int err_count = 0, tests_run = 0, cyc = 0, n = 0;

	reset_watchdog_prog_entry #(.REINIT_CYCLES(RC), .WDT_CYCLES(WC), .ISP_HOLD_CYCLES(HC)) dut_u (.clk_sys_i,
		.rstn_i, .power_good_i, .supply_low_i, .reset_pin_n_i, .xtal_stable_i, .sw_reset_i, .wdt_clear_i,
		.wdt_mask_i, .power_down_i, .apm_request_i, .unlock_cmd_i, .uart_tx_data_i, .cpu_reset_n_o,
		.reset_cause_o, .gpio_hiz_pullup_o, .prog_mode_o, .flash_wr_uart_en_o, .flash_wr_usb_en_o, .txd_o,
		.txd_oe_o);
	host_model host_u (.clk_sys_i, .go_i(host_go), .low_cycles_i(low_len), .unlock_go_i(unlock_go),
		.pin_n_o(reset_pin_n_i), .unlock_o(unlock_cmd_i));

	// 40 MHz clock
	initial forever #12.5 clk_sys_i = ~clk_sys_i;

	// Cut a hang short
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 8000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask
	// Bounded wait for the processor reset to reach a level
	task automatic wait_cpu(input logic lv);
		n = 0;
		while (cpu_reset_n_o !== lv && n < 300) begin
			@(posedge clk_sys_i);
			n++;
		end
	endtask
	task automatic kick;
		@(posedge clk_sys_i) wdt_clear_i <= 1;
		@(posedge clk_sys_i) wdt_clear_i <= 0;
	endtask
	task automatic pin(input int len);
		@(posedge clk_sys_i) begin
			low_len <= len;
			host_go <= 1;
		end
		@(posedge clk_sys_i) host_go <= 0;
		tick(len + 1);
	endtask
	// Reset seen, then released in time with the right cause
	task automatic reset_seen(input reset_cause_t c, input logic g);
		wait_cpu(0);
		check("gpio state", gpio_hiz_pullup_o, g);
		check("txd enable", txd_oe_o, 0);
		wait_cpu(1);
		check("release time", n <= RC + 10, 1);
		check("cause", reset_cause_o, c);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h071eacd5));
		tick(8);
		rstn_i <= 1;
		tick(20);
		check("held without supply", cpu_reset_n_o, 0);
		@(posedge clk_sys_i) power_good_i <= 1;
		reset_seen(CAUSE_POR, 1);
		check("default mode", prog_mode_o, PROG_NORMAL);
		@(posedge clk_sys_i) xtal_stable_i <= 1;
		// Transmit line follows the serial data one cycle late
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys_i);
			check("txd", txd_o, hist[1]);
			hist = {hist[0], 1'($urandom)};
			uart_tx_data_i <= hist[0];
		end
		// Kicks inside the interval keep it running; then let it expire
		for (int i = 0; i < 4; i++) begin
			kick();
			tick($urandom_range(WC - 10, WC / 2));
			check("running after kick", cpu_reset_n_o, 1);
		end
		kick();
		wait_cpu(0);
		check("overflow time", n >= WC - 4 && n <= WC + 4, 1);
		wait_cpu(1);
		check("cause", reset_cause_o, CAUSE_WDT);
		// Masked and powered-down spans must never drop the processor
		@(posedge clk_sys_i) wdt_mask_i <= 1;
		wait_cpu(0);
		check("masked watchdog", n, 300);
		@(posedge clk_sys_i) wdt_mask_i <= 0;
		kick();
		// Power down in mid-interval; a whole interval must follow the wake
		tick(WC / 2);
		@(posedge clk_sys_i) power_down_i <= 1;
		wait_cpu(0);
		check("power down", n, 300);
		@(posedge clk_sys_i) power_down_i <= 0;
		wait_cpu(0);
		check("restart cleared", n >= WC - 4 && n <= WC + 4, 1);
		wait_cpu(1);
		check("wake cause", reset_cause_o, CAUSE_WDT);
		// Pin reset with crystal slow, so the timeout ends reinit
		@(posedge clk_sys_i) xtal_stable_i <= 0;
		pin($urandom_range(10, 3));
		reset_seen(CAUSE_PIN, 1);
		@(posedge clk_sys_i) xtal_stable_i <= 1;
		// Supply drop alone, with the pin, and under power-on
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys_i) begin
				supply_low_i <= (k < 2);
				power_good_i <= (k != 2);
				low_len <= 8;
				host_go <= (k > 0);
			end
			@(posedge clk_sys_i) host_go <= 0;
			tick(8);
			@(posedge clk_sys_i) begin
				supply_low_i <= 0;
				power_good_i <= 1;
			end
			reset_seen(k == 2 ? CAUSE_POR : CAUSE_BOR, 1);
		end
		@(posedge clk_sys_i) sw_reset_i <= 1;
		@(posedge clk_sys_i) sw_reset_i <= 0;
		reset_seen(CAUSE_SOFT, 0);
		// Unlock while running is ignored; short hold gives plain reset
		@(posedge clk_sys_i) unlock_go <= 1;
		@(posedge clk_sys_i) unlock_go <= 0;
		tick(4);
		check("unlock in run", prog_mode_o, PROG_NORMAL);
		pin(HC - 8);
		reset_seen(CAUSE_PIN, 1);
		check("short hold mode", prog_mode_o, PROG_NORMAL);
		// Long hold, then unlock: serial programming
		pin(HC + 12);
		check("wait unlock", prog_mode_o, PROG_WAIT_UNLOCK);
		check("txd enable", txd_oe_o, 0);
		// Let the released pin pass the input filter before unlocking
		tick(4);
		@(posedge clk_sys_i) unlock_go <= 1;
		@(posedge clk_sys_i) unlock_go <= 0;
		tick(3);
		check("isp mode", prog_mode_o, PROG_ISP);
		check("isp txd", txd_oe_o, 1);
		check("isp flash", {flash_wr_uart_en_o, flash_wr_usb_en_o}, 2'b10);
		pin(6);
		reset_seen(CAUSE_PIN, 1);
		check("isp left", prog_mode_o, PROG_NORMAL);
		// Auto programming taken at the next reset
		@(posedge clk_sys_i) apm_request_i <= 1;
		@(posedge clk_sys_i) apm_request_i <= 0;
		@(posedge clk_sys_i) sw_reset_i <= 1;
		@(posedge clk_sys_i) sw_reset_i <= 0;
		tick(RC + 10);
		check("apm mode", prog_mode_o, PROG_APM);
		check("apm flash", {flash_wr_uart_en_o, flash_wr_usb_en_o}, 2'b11);
		pin(6);
		reset_seen(CAUSE_PIN, 1);
		check("apm left", prog_mode_o, PROG_NORMAL);
		tally_and_finish();
	end
endmodule
